// file: hw/load_line_calc.v
// Load-line offset for one output page from a linear-11 slope word.
// Assumes output current arrives in whole amperes as a signed word on this clock.
module load_line_calc (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [15:0] slope_word_i,
  input wire signed [15:0] iout_i,
  output reg signed [23:0] drop_mv_o
);

  wire signed [4:0] exp_n = slope_word_i[15:11];
  wire signed [10:0] mant_y = slope_word_i[10:0];
  wire signed [26:0] raw = iout_i * mant_y;
  wire [4:0] right_amt = 5'h00 - exp_n;
  wire signed [26:0] scaled = exp_n[4] ? (raw >>> right_amt) : (raw <<< exp_n[3:0]);

  // The drop follows current sign, so a sinking rail sees a negative drop, i.e. a rise.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drop_mv_o <= 24'h000000;
    end else begin
      drop_mv_o <= scaled[23:0];
    end
  end

endmodule

// file: hw/pmbus_margin_droop_freq_config.v
// Command registers for margin setpoints, load line, switching rate and interleave.
// Assumes a PMBus front end hands over decoded word commands, and that straps are pins.
`include "pmbus_cfg_defs.vh"
module pmbus_margin_droop_freq_config (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] cmd_code_i,
  input wire cmd_page_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [15:0] cmd_wdata_i,
  output reg [15:0] cmd_rdata_o,
  output reg cmd_ack_o,
  output reg cmd_err_o,
  input wire [15:0] voltage_select_strap_i,
  input wire [15:0] sync_strap_i,
  input wire [15:0] cfg_slope_strap_i,
  input wire [15:0] cfg_phase_strap_i,
  input wire [31:0] vout_command_i,
  input wire [31:0] vout_max_i,
  input wire [3:0] op_state_i,
  input wire [31:0] iout_i,
  input wire share_auto_i,
  input wire [3:0] share_slot_i,
  output reg [31:0] vout_target_o,
  output wire [47:0] drop_mv_o,
  output reg [6:0] rate_divisor_o,
  output reg [3:0] phase0_step_o,
  output reg [3:0] phase1_step_o,
  output reg straps_loaded_o
);

  // Linear-11 word to a signed integer, fraction dropped.
  function signed [31:0] lin11;
    input [15:0] w;
    reg signed [31:0] m;
    reg [4:0] e;
    begin
      m = {{21{w[10]}}, w[10:0]};
      e = w[15:11];
      if (e[4]) begin
        lin11 = m >>> (5'h00 - e);
      end else begin
        lin11 = m <<< e[3:0];
      end
    end
  endfunction

  // Three-stage strap synchronisers; only stages two and three are compared.
  reg [63:0] strap_s1;
  reg [63:0] strap_s2;
  reg [63:0] strap_s3;
  wire [63:0] strap_raw = {cfg_phase_strap_i, cfg_slope_strap_i, sync_strap_i, voltage_select_strap_i};
  reg [1:0] strap_fill;
  // All stages reset to zero and would agree at once, which would load zero defaults.
  // Wait until stage three holds a sampled pin value before the compare may count.
  wire strap_stable = (strap_s2 == strap_s3) && (strap_fill == 2'h3);

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_s1 <= 64'h0000000000000000;
      strap_s2 <= 64'h0000000000000000;
      strap_s3 <= 64'h0000000000000000;
      strap_fill <= 2'h0;
    end else begin
      if (strap_fill != 2'h3) begin
        strap_fill <= strap_fill + 2'h1;
      end
      strap_s1 <= strap_raw;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  // Command registers; margin and slope are paged, rate and interleave are global.
  reg [15:0] margin_upper_setpoint [0:1];
  reg [15:0] margin_lower_setpoint [0:1];
  reg [15:0] load_line_slope [0:1];
  reg [15:0] switching_rate_select;
  reg [15:0] phase_position_config;
  reg load_pending;

  wire [15:0] strap_vsel = strap_s3[15:0];
  wire [31:0] up_prod = strap_vsel * `UPPER_MUL;
  wire [31:0] lo_prod = strap_vsel * `LOWER_MUL;
  wire [31:0] up_dflt = up_prod / {16'h0000, `MARGIN_DIV};
  wire [31:0] lo_dflt = lo_prod / {16'h0000, `MARGIN_DIV};

  // Write checks on the addressed page.
  wire [15:0] page_max = cmd_page_i ? vout_max_i[31:16] : vout_max_i[15:0];
  wire [15:0] margin_wr = (cmd_wdata_i > page_max) ? page_max : cmd_wdata_i;
  wire signed [31:0] wr_val = lin11(cmd_wdata_i);
  wire slope_ok = (wr_val >= 0) && (wr_val <= $signed(`SLOPE_MAX_MV));
  wire rate_ok = (wr_val >= $signed(`RATE_MIN_KHZ)) && (wr_val <= $signed(`RATE_MAX_KHZ));
  wire known = (cmd_code_i == `CMD_MARGIN_UPPER) || (cmd_code_i == `CMD_MARGIN_LOWER) ||
               (cmd_code_i == `CMD_LOAD_LINE) || (cmd_code_i == `CMD_SWITCH_RATE) ||
               (cmd_code_i == `CMD_PHASE_POS);

  // Defaults load once the straps agree after reset; earlier commands are refused, and one in the load cycle goes unanswered.
  // Out-of-range slope and rate writes are refused whole, keeping the old value,
  // because a silently clamped rate would still move the PWM mid-conversion.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      margin_upper_setpoint[0] <= 16'h0000;
      margin_upper_setpoint[1] <= 16'h0000;
      margin_lower_setpoint[0] <= 16'h0000;
      margin_lower_setpoint[1] <= 16'h0000;
      load_line_slope[0] <= 16'h0000;
      load_line_slope[1] <= 16'h0000;
      switching_rate_select <= 16'h0000;
      phase_position_config <= 16'h0000;
      load_pending <= 1'b1;
      straps_loaded_o <= 1'b0;
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      cmd_rdata_o <= 16'h0000;
    end else begin
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      if (load_pending && strap_stable) begin
        load_pending <= 1'b0;
        straps_loaded_o <= 1'b1;
        margin_upper_setpoint[0] <= up_dflt[15:0];
        margin_upper_setpoint[1] <= up_dflt[15:0];
        margin_lower_setpoint[0] <= lo_dflt[15:0];
        margin_lower_setpoint[1] <= lo_dflt[15:0];
        load_line_slope[0] <= strap_s3[47:32];
        load_line_slope[1] <= strap_s3[47:32];
        switching_rate_select <= strap_s3[31:16];
        phase_position_config <= strap_s3[63:48];
      end else if (cmd_wr_i || cmd_rd_i) begin
        cmd_ack_o <= 1'b1;
        cmd_rdata_o <= 16'h0000;
        if (load_pending || !known) begin
          cmd_err_o <= 1'b1;
        end else if (cmd_wr_i) begin
          case (cmd_code_i)
            `CMD_MARGIN_UPPER: begin
              margin_upper_setpoint[cmd_page_i] <= margin_wr;
            end
            `CMD_MARGIN_LOWER: begin
              margin_lower_setpoint[cmd_page_i] <= margin_wr;
            end
            `CMD_LOAD_LINE: begin
              if (slope_ok) begin
                load_line_slope[cmd_page_i] <= cmd_wdata_i;
              end else begin
                cmd_err_o <= 1'b1;
              end
            end
            `CMD_SWITCH_RATE: begin
              if (rate_ok) begin
                switching_rate_select <= cmd_wdata_i;
              end else begin
                cmd_err_o <= 1'b1;
              end
            end
            default: begin
              phase_position_config <= cmd_wdata_i;
            end
          endcase
        end else begin
          case (cmd_code_i)
            `CMD_MARGIN_UPPER: cmd_rdata_o <= margin_upper_setpoint[cmd_page_i];
            `CMD_MARGIN_LOWER: cmd_rdata_o <= margin_lower_setpoint[cmd_page_i];
            `CMD_LOAD_LINE: cmd_rdata_o <= load_line_slope[cmd_page_i];
            `CMD_SWITCH_RATE: cmd_rdata_o <= switching_rate_select;
            default: cmd_rdata_o <= phase_position_config;
          endcase
        end
      end
    end
  end

  // Per page: pick the target from the operation state, clamp it, and form the drop.
  wire [31:0] clamped;
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : page
      wire [1:0] op = op_state_i[2 * p + 1:2 * p];
      wire [15:0] vmax = vout_max_i[16 * p + 15:16 * p];
      wire [15:0] pick = (op == `OP_MARGIN_UPPER) ? margin_upper_setpoint[p] :
                         (op == `OP_MARGIN_LOWER) ? margin_lower_setpoint[p] :
                         vout_command_i[16 * p + 15:16 * p];

      assign clamped[16 * p + 15:16 * p] = (pick > vmax) ? vmax : pick;

      load_line_calc slope_unit (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .slope_word_i(load_line_slope[p]),
        .iout_i(iout_i[16 * p + 15:16 * p]),
        .drop_mv_o(drop_mv_o[24 * p + 23:24 * p])
      );
    end
  endgenerate

  // Both pages register in one process, so the target word has a single driver.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vout_target_o <= 32'h00000000;
    end else begin
      vout_target_o <= clamped;
    end
  end

  // Divisor is the nearest integer to the reference over the rate, held to its legal span.
  wire signed [31:0] rate_khz = lin11(switching_rate_select);
  wire [31:0] rate_safe = (rate_khz > 0) ? rate_khz : 32'h00000001;
  wire [31:0] div_raw = (`REF_KHZ + (rate_safe >> 1)) / rate_safe;
  wire [31:0] div_lim = (div_raw < `DIV_MIN) ? `DIV_MIN : (div_raw > `DIV_MAX) ? `DIV_MAX : div_raw;

  // Phase step of 22.5 degrees; modulo 16 steps is the 360-degree wrap.
  wire [3:0] pos = phase_position_config[`POS_LSB + 3:`POS_LSB];
  wire [3:0] cnt_raw = phase_position_config[`COUNT_LSB + 3:`COUNT_LSB];
  wire [8:0] cnt = (cnt_raw == 4'h0) ? 9'h001 : {5'h00, cnt_raw};
  wire [8:0] twice = {pos, 5'h00} / cnt;
  wire [8:0] rounded = (twice + 9'h001) >> 1;
  wire [3:0] step = share_auto_i ? share_slot_i : rounded[3:0];

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_divisor_o <= 7'h00;
      phase0_step_o <= 4'h0;
      phase1_step_o <= 4'h0;
    end else begin
      rate_divisor_o <= div_lim[6:0];
      phase0_step_o <= step;
      phase1_step_o <= step + `HALF_TURN_STEPS;
    end
  end

endmodule

// file: pkg/pmbus_cfg_defs.vh
// Constants for the PMBus margin, load-line, switching-rate and phase block.
// Assumes command codes arrive already decoded from the serial PMBus layer.
// Function
// - 25h holds the margin-high output target.
// - Margin-high default is 1.05 times strap voltage.
// - 26h holds the margin-low output target.
// - Margin-low default is 0.95 times strap voltage.
// - Margin words: paged 16-bit unsigned, two bytes.
// - Any target above maximum regulates at maximum.
// - Slope word uses linear-11 exponent and mantissa.
// - Sinking current raises the output by slope.
// - 33h global switching rate, strap default overridable.
// - Rate is 16 MHz over divisor 12..80.
// - Rate default from sync strap, span 615-800 kHz.
// - 37h sets phase position on shared sync.
// - Single share group assigns phase automatically.
// - Second phase runs 180 degrees after first.
// - Offset is rounded position*16/count times 22.5.
`ifndef PMBUS_CFG_DEFS_VH
`define PMBUS_CFG_DEFS_VH
`define CMD_MARGIN_UPPER 8'h25
`define CMD_MARGIN_LOWER 8'h26
`define CMD_LOAD_LINE 8'h28
`define CMD_SWITCH_RATE 8'h33
`define CMD_PHASE_POS 8'h37
`define OP_NOMINAL 2'h0
`define OP_MARGIN_UPPER 2'h1
`define OP_MARGIN_LOWER 2'h2
`define UPPER_MUL 16'h0015
`define LOWER_MUL 16'h0013
`define MARGIN_DIV 16'h0014
`define SLOPE_MAX_MV 32'h00000028
`define RATE_MIN_KHZ 32'h00000267
`define RATE_MAX_KHZ 32'h00000320
`define REF_KHZ 32'h00003E80
`define DIV_MIN 32'h0000000C
`define DIV_MAX 32'h00000050
`define HALF_TURN_STEPS 4'h8
`define POS_LSB 0
`define COUNT_LSB 4
`endif

// file: test/pmbus_cfg_sva.sv
// Checker on the command port and the derived outputs of the configuration block.
// Assumes one clock domain with the asynchronous active-high reset.
module pmbus_cfg_sva (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] cmd_code_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [15:0] cmd_rdata_o,
  input wire cmd_ack_o,
  input wire cmd_err_o,
  input wire [6:0] rate_divisor_o,
  input wire [3:0] phase0_step_o,
  input wire [3:0] phase1_step_o,
  input wire straps_loaded_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Strobes before the defaults are in, when answered, must carry an error.
  wire strb = cmd_wr_i | cmd_rd_i;
  wire known = cmd_code_i inside {8'h25, 8'h26, 8'h28, 8'h33, 8'h37};
  sequence s_taken; strb && straps_loaded_o; endsequence
  sequence s_early; strb && !straps_loaded_o ##1 cmd_ack_o; endsequence
  // Derived outputs lag the loaded registers by one edge, so wait a cycle first.
  sequence s_settled; straps_loaded_o ##1 straps_loaded_o; endsequence
  property p_ack; s_taken |=> cmd_ack_o; endproperty
  property p_idle; !strb |=> !cmd_ack_o && $stable(cmd_rdata_o); endproperty
  property p_early; s_early |-> cmd_err_o; endproperty
  property p_unknown; s_taken ##0 !known |=> cmd_err_o && cmd_rdata_o == 16'h0000; endproperty
  property p_wr0; s_taken ##0 cmd_wr_i |=> cmd_rdata_o == 16'h0000; endproperty
  property p_errack; cmd_err_o |-> cmd_ack_o; endproperty
  property p_div; s_settled |-> rate_divisor_o >= 7'h0C && rate_divisor_o <= 7'h50; endproperty
  property p_phase; s_settled |-> phase1_step_o == phase0_step_o + 4'h8; endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge after a taken strobe");
  a_idle: assert property (p_idle) else $error("answer changed without a strobe");
  a_early: assert property (p_early) else $error("early strobe not refused");
  a_unknown: assert property (p_unknown) else $error("unknown code not refused");
  a_wr0: assert property (p_wr0) else $error("read word not zero after a write");
  a_errack: assert property (p_errack) else $error("error without acknowledge");
  a_div: assert property (p_div) else $error("divisor out of span");
  a_phase: assert property (p_phase) else $error("second phase not half a turn later");
endmodule
bind pmbus_margin_droop_freq_config pmbus_cfg_sva chk (.sys_clk_i, .rst_i, .cmd_code_i, .cmd_wr_i, .cmd_rd_i,
  .cmd_rdata_o, .cmd_ack_o, .cmd_err_o, .rate_divisor_o, .phase0_step_o, .phase1_step_o, .straps_loaded_o);

// file: test/pmbus_host_model.sv
// Host model that issues decoded word commands to the configuration block.
// Assumes a one-cycle acknowledge after each strobe, sampled on the rising edge.
module pmbus_host_model (
  input wire sys_clk_i,
  input wire cmd_ack_i,
  input wire cmd_err_i,
  input wire [15:0] cmd_rdata_i,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic cmd_page_o = 1'b0,
  output logic cmd_wr_o = 1'b0,
  output logic cmd_rd_o = 1'b0,
  output logic [15:0] cmd_wdata_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // One command; code, page and data hold until the acknowledge is seen.
  // Slopes and interleave words come from this single host, rates only with the output off.
  task xfer(input w, input [7:0] c, input p, input [15:0] d, output [15:0] q, output e, output t);
    integer i;
    @(posedge sys_clk_i);
    cmd_wr_o <= w;
    cmd_rd_o <= !w;
    cmd_code_o <= c;
    cmd_page_o <= p;
    cmd_wdata_o <= d;
    @(posedge sys_clk_i);
    cmd_wr_o <= 1'b0;
    cmd_rd_o <= 1'b0;
    t = 1'b1;
    q = 16'h0000;
    e = 1'b0;
    for (i = 0; i < 8 && t; i++) begin
      @(posedge sys_clk_i);
      if (cmd_ack_i === 1'b1) begin
        q = cmd_rdata_i;
        e = cmd_err_i;
        t = 1'b0;
      end
    end
    // Released data no longer shows the old word, so a stale capture cannot pass.
    cmd_wdata_o <= ~d;
  endtask
endmodule

// file: test/pmbus_margin_droop_freq_config_tb_top.sv
// Self-checking bench: the host model drives commands, the bench drives straps and loop inputs.
// Assumes the block, its header and the host model are compiled first; one 100 MHz clock.
module pmbus_margin_droop_freq_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, share_auto_i = 1'b0, p;
  logic [15:0] voltage_select_strap_i = 16'h2000, sync_strap_i = 16'h02BC, q, d;
  logic [15:0] cfg_slope_strap_i = 16'h000A, cfg_phase_strap_i = 16'h0000;
  logic [31:0] vout_command_i = 32'h1000_1000, vout_max_i = 32'hFFFF_FFFF, iout_i = 32'h0000_0000;
  logic [3:0] op_state_i = 4'h0, share_slot_i = 4'h5;
  wire [7:0] cmd_code_i;
  wire cmd_page_i, cmd_wr_i, cmd_rd_i, cmd_ack_o, cmd_err_o, straps_loaded_o;
  wire [15:0] cmd_wdata_i, cmd_rdata_o;
  wire [31:0] vout_target_o;
  wire [47:0] drop_mv_o;
  wire [6:0] rate_divisor_o;
  wire [3:0] phase0_step_o, phase1_step_o;
  logic e, t;
  integer num_errors = 0, checks_done = 0, seed = 15544, i;
  int khz[4] = '{615, 700, 800, 800};
  logic [15:0] word[4] = '{16'h0267, 16'h095E, 16'h0320, 16'h0321};
  pmbus_margin_droop_freq_config dut (.sys_clk_i, .rst_i, .cmd_code_i, .cmd_page_i, .cmd_wr_i, .cmd_rd_i,
    .cmd_wdata_i, .cmd_rdata_o, .cmd_ack_o, .cmd_err_o, .voltage_select_strap_i, .sync_strap_i,
    .cfg_slope_strap_i, .cfg_phase_strap_i, .vout_command_i, .vout_max_i, .op_state_i, .iout_i,
    .share_auto_i, .share_slot_i, .vout_target_o, .drop_mv_o, .rate_divisor_o, .phase0_step_o,
    .phase1_step_o, .straps_loaded_o);
  pmbus_host_model host (.sys_clk_i, .cmd_ack_i(cmd_ack_o), .cmd_err_i(cmd_err_o), .cmd_rdata_i(cmd_rdata_o),
    .cmd_code_o(cmd_code_i), .cmd_page_o(cmd_page_i), .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i),
    .cmd_wdata_o(cmd_wdata_i));
  // Expected values, worked out from the documented formulas.
  function [6:0] exp_div(input integer f);
    integer n;
    n = (16000 + f / 2) / f;
    exp_div = 7'(n < 12 ? 12 : n > 80 ? 80 : n);
  endfunction
  function [15:0] exp_margin(input [15:0] v, input integer m);
    exp_margin = 16'((v * m) / 20);
  endfunction
  function [7:0] exp_phase(input integer s);
    exp_phase = {4'((s + 8) % 16), 4'(s % 16)};
  endfunction
  task check(input [47:0] seen, input [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A command that is never answered ends the run at once.
  task cmd(input w, input [7:0] c, input pg, input [15:0] dd, input ee);
    host.xfer(w, c, pg, dd, q, e, t);
    if (t) begin
      num_errors++;
      finish_test();
    end
    check(e, ee);
  endtask
  task rdk(input [7:0] c, input pg, input [15:0] x);
    cmd(1'b0, c, pg, 16'h0000, 1'b0);
    check(q, x);
  endtask
  // Outputs follow one edge after a store, so let them land before looking.
  task settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  initial forever #5 sys_clk_i = ~sys_clk_i;
  initial begin
    repeat (3) @(posedge sys_clk_i);
    fork
      cmd(1'b0, 8'h25, 1'b0, 16'h0000, 1'b1);
      @(posedge sys_clk_i) rst_i <= 1'b0;
    join
    for (i = 0; i < 8 && straps_loaded_o !== 1'b1; i++) @(posedge sys_clk_i);
    check(straps_loaded_o, 1'b1);
    if (straps_loaded_o !== 1'b1) finish_test();
    settle;
    rdk(8'h25, 1'b0, exp_margin(voltage_select_strap_i, 21));
    rdk(8'h26, 1'b1, exp_margin(voltage_select_strap_i, 19));
    rdk(8'h33, 1'b0, 16'h02BC);
    check(rate_divisor_o, exp_div(700));
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      p = 1'($random(seed));
      cmd(1'b1, i[0] ? 8'h26 : 8'h25, p, d, 1'b0);
      rdk(i[0] ? 8'h26 : 8'h25, p, d);
    end
    $display("defaults and margin words done");
    @(posedge sys_clk_i) begin
      vout_max_i <= 32'hFFFF_3000;
      op_state_i <= 4'h1;
    end
    cmd(1'b1, 8'h25, 1'b0, 16'h4000, 1'b0);
    rdk(8'h25, 1'b0, 16'h3000);
    settle;
    check(vout_target_o[15:0], 16'h3000);
    cmd(1'b1, 8'h26, 1'b0, 16'h0800, 1'b0);
    @(posedge sys_clk_i) op_state_i <= 4'h2;
    settle;
    check(vout_target_o[15:0], 16'h0800);
    @(posedge sys_clk_i) begin
      op_state_i <= 4'h0;
      vout_command_i <= 32'h1000_7000;
    end
    settle;
    check(vout_target_o, 32'h1000_3000);
    cmd(1'b1, 8'h25, 1'b1, 16'h1234, 1'b0);
    @(posedge sys_clk_i) op_state_i <= 4'h7;
    settle;
    check(vout_target_o, 32'h1234_3000);
    $display("margin and clamp done");
    cmd(1'b1, 8'h28, 1'b0, 16'h0029, 1'b1);
    cmd(1'b1, 8'h28, 1'b0, 16'hF828, 1'b0);
    rdk(8'h28, 1'b0, 16'hF828);
    @(posedge sys_clk_i) iout_i <= 32'h0003_FFFB;
    settle;
    check(drop_mv_o, {24'(3 * 10), 24'(-5 * 20)});
    $display("load line done");
    for (i = 0; i < 4; i++) begin
      cmd(1'b1, 8'h33, 1'b0, word[i], i == 3);
      settle;
      check(rate_divisor_o, exp_div(khz[i]));
    end
    $display("switching rate done");
    cmd(1'b1, 8'h37, 1'b0, 16'h0041, 1'b0);
    settle;
    check({phase1_step_o, phase0_step_o}, exp_phase((1 * 32 / 4 + 1) / 2));
    cmd(1'b1, 8'h37, 1'b0, 16'h0023, 1'b0);
    rdk(8'h37, 1'b0, 16'h0023);
    settle;
    check({phase1_step_o, phase0_step_o}, exp_phase((3 * 32 / 2 + 1) / 2));
    @(posedge sys_clk_i) share_auto_i <= 1'b1;
    settle;
    check({phase1_step_o, phase0_step_o}, exp_phase(5));
    cmd(1'b1, 8'h24, 1'b0, 16'h1234, 1'b1);
    cmd(1'b0, 8'h30, 1'b1, 16'h0000, 1'b1);
    $display("interleave and unknown codes done");
    finish_test();
  end
endmodule
